// File: pkg/ccr_pkg.sv
// Package for the control register bank: offsets, fields and types.
package ccr_pkg;

   // =====================================================================
   // Control register numbers.
   // =====================================================================
   localparam logic [4:0] CR_RECOVERY = 5'h00;
   localparam logic [4:0] CR_COPROC = 5'h0a;
   localparam logic [4:0] CR_SHIFT = 5'h0b;
   localparam logic [4:0] CR_IVB = 5'h0e;
   localparam logic [4:0] CR_EXT_MASK = 5'h0f;
   localparam logic [4:0] CR_TIMER = 5'h10;
   localparam logic [4:0] CR_IAQ = 5'h12;
   localparam logic [4:0] CR_IIR = 5'h13;
   localparam logic [4:0] CR_IOR = 5'h15;
   localparam logic [4:0] CR_IPSW = 5'h16;
   localparam logic [4:0] CR_EXT_REQ = 5'h17;
   localparam logic [4:0] CR_TEMP_FIRST = 5'h18;
   localparam logic [4:0] CR_TEMP_26 = 5'h1a;
   localparam logic [4:0] CR_TEMP_27 = 5'h1b;
   localparam logic [4:0] CR_TEMP_LAST = 5'h1f;

   // =====================================================================
   // Configuration register indices.
   // =====================================================================
   localparam logic [2:0] CFG_INTERNAL = 3'h0;
   localparam logic [2:0] CFG_TEST_A = 3'h1;
   localparam logic [2:0] CFG_TEST_B = 3'h2;
   localparam logic [2:0] CFG_MEM_FIRST = 3'h3;
   localparam logic [2:0] CFG_MEM_LAST = 3'h6;
   localparam logic [2:0] CFG_PC_DEBUG = 3'h7;

   // =====================================================================
   // Field positions and widths.
   // =====================================================================
   localparam int SHIFT_W = 5;
   localparam int COPROC_W = 8;
   localparam int EXT_REQ_W = 12;
   localparam int ICACHE_BIT = 0;
   localparam int DCACHE_BIT = 1;
   localparam logic [31:0] RESET_VALUE = 32'h0000_0000;

   // =====================================================================
   // Status word enables, a control access and its answer.
   // =====================================================================
   typedef struct packed {
      logic recovery_en;
      logic collect_en;
      logic unmask_en;
      logic secure_timer;
   } ccr_status_t;

   typedef struct packed {
      logic valid;
      logic write;
      logic privileged;
      logic [4:0] num;
      logic [31:0] wdata;
   } ccr_access_t;

   typedef struct packed {
      logic valid;
      logic trap;
      logic [31:0] rdata;
   } ccr_answer_t;

endpackage : ccr_pkg

// File: hw/ccr_bank.sv
// Control register bank of the processor core with its side effects.
//
// How it works
// (RULE1) Recovery enable: decrement, trap on bit zero
// (RULE2) Collect interruption state only when enabled
// (RULE3) Unmask bit gates external, power, machine-check
// (RULE4) Registers zero and eight to thirty-one
// (RULE5) Numbers 8,9,12,13,17,20 are nonexistent
// (RULE6) Shift field five bits; coprocessor eight bits
// (RULE7) Shift register accessible at any privilege
// (RULE8) Timer open unless secure bit set
// (RULE9) Registers 26,27 readable by all, privileged write
// (RULE10) All other registers privileged access only
// (RULE11) Request bit 0 timer, bit 3 serial two
// (RULE12) Request bits 4..7 are PCI lines
// (RULE13) Bits 8..11 parallel, serial, DMA, counter
// (RULE14) Eight config registers; last via emulation port
// (RULE15) Config zero cache/burst/order; 3..6 memory settings
// (RULE16) Software never touches config one or two
// (RULE17) Instruction cache toggle invalidates instruction cache
// (RULE18) Data cache enable invalidates without write-back
// (RULE19) Data cache disable leaves entries untouched
// (RULE20) Software flushes data cache before disabling
// (RULE21) Read of nonexistent register returns zero
// (RULE22) Write to nonexistent register does nothing
// (RULE23) Unprivileged access traps, register unchanged
`timescale 1ns/1ps
`default_nettype none

module ccr_bank
(
   // Clock, reset and clock enable.
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // Status word enables.
   input wire ccr_pkg::ccr_status_t status_in,
   // Control register access from the core.
   input wire ccr_pkg::ccr_access_t access_in,
   output ccr_pkg::ccr_answer_t answer_out,
   // Configuration register access from the core.
   input wire logic cfg_valid,
   input wire logic cfg_write,
   input wire logic [2:0] cfg_index,
   input wire logic [31:0] cfg_wdata,
   output logic [31:0] cfg_rdata,
   // Emulation port access to the program counter copy.
   input wire logic emu_write,
   input wire logic [31:0] emu_wdata,
   output logic [31:0] emu_rdata,
   // Interruption events and captured state.
   input wire logic interruption,
   input wire logic [31:0] int_addr,
   input wire logic [31:0] int_instr,
   input wire logic [31:0] int_offset,
   input wire logic [31:0] int_status,
   // Raw external request sources, bit per request.
   input wire logic [11:0] ext_sources,
   input wire logic power_fail,
   input wire logic mc_low,
   // Outputs toward the core.
   output logic recovery_trap,
   output logic ext_interrupt,
   output logic icache_inval,
   output logic dcache_inval,
   output logic [11:0] ext_requests
);

   // ====================================================================
   // Storage.
   // ====================================================================
   // General 32-bit control registers indexed by number.
   logic [31:0] cr_r [32];
   // Coprocessor and shift fields, narrow by design.
   logic [7:0] coproc_r;
   logic [4:0] shift_r;
   // Configuration registers; index 1 and 2 are not stored.
   logic [31:0] cfg_r [8];
   // Registered outputs.
   ccr_pkg::ccr_answer_t answer_r;
   logic [31:0] cfg_rdata_r;
   logic trap_r;
   logic ext_int_r;
   logic icache_inval_r;
   logic dcache_inval_r;

   // ====================================================================
   // Decode.
   // ====================================================================
   // True for numbers that hold state.
   function automatic logic is_present(input logic [4:0] n);
      is_present = (n == ccr_pkg::CR_RECOVERY) ||
         ((n >= 5'h08) && (n != 5'h08) && (n != 5'h09) && // RULE4
          (n != 5'h0c) && (n != 5'h0d) && (n != 5'h11) &&
          (n != 5'h14)); // RULE5
   endfunction : is_present

   // Whether this access has the privilege it needs.
   function automatic logic allowed(input ccr_pkg::ccr_access_t a,
                                    input logic secure);
      if (a.privileged)
         allowed = 1'b1;
      else if (a.num == ccr_pkg::CR_SHIFT)
         allowed = 1'b1; // RULE7
      else if (a.num == ccr_pkg::CR_TIMER)
         allowed = !secure; // RULE8
      else if ((a.num == ccr_pkg::CR_TEMP_26) ||
               (a.num == ccr_pkg::CR_TEMP_27))
         allowed = !a.write; // RULE9
      else
         allowed = 1'b0; // RULE10
   endfunction : allowed

   // Access decode.
   wire logic acc_ok = allowed(access_in, status_in.secure_timer);
   wire logic acc_live = access_in.valid && is_present(access_in.num);
   wire logic acc_wr = acc_live && acc_ok && access_in.write; // RULE22
   wire logic acc_trap = access_in.valid && !acc_ok; // RULE23
   // Recovery counter decrement and trap condition.
   wire logic rc_run = status_in.recovery_en; // RULE1
   wire logic rc_trap = rc_run && cr_r[ccr_pkg::CR_RECOVERY][0]; // RULE1
   // Interruption state capture.
   wire logic capture = interruption && status_in.collect_en; // RULE2
   // Masked external events.
   wire logic [11:0] pend = cr_r[ccr_pkg::CR_EXT_REQ][11:0] &
      cr_r[ccr_pkg::CR_EXT_MASK][11:0];
   wire logic ext_raw = status_in.unmask_en &&
      ((|pend) || power_fail || mc_low); // RULE3
   // Cache enable bits in configuration register zero.
   wire logic cfg0_wr = cfg_valid && cfg_write &&
      (cfg_index == ccr_pkg::CFG_INTERNAL);
   wire logic ic_old = cfg_r[0][ccr_pkg::ICACHE_BIT];
   wire logic dc_old = cfg_r[0][ccr_pkg::DCACHE_BIT];
   wire logic ic_new = cfg_wdata[ccr_pkg::ICACHE_BIT];
   wire logic dc_new = cfg_wdata[ccr_pkg::DCACHE_BIT];
   wire logic ic_toggle = cfg0_wr && (ic_old != ic_new); // RULE17
   wire logic dc_enable = cfg0_wr && !dc_old && dc_new; // RULE18
   // Read data for a control register.
   logic [31:0] rd_mux;
   always_comb
   begin
      // Nonexistent numbers read as zero.
      rd_mux = 32'h0000_0000; // RULE21
      if (access_in.num == ccr_pkg::CR_SHIFT)
         rd_mux = {27'h0000000, shift_r}; // RULE6
      else if (access_in.num == ccr_pkg::CR_COPROC)
         rd_mux = {24'h000000, coproc_r}; // RULE6
      else if (is_present(access_in.num))
         rd_mux = cr_r[access_in.num];
   end

   // ====================================================================
   // Control registers.
   // ====================================================================
   // Per-register update with hardware effects; events apply on top of writes.
   genvar gi;
   generate
      for (gi = 0; gi < 32; gi++)
      begin : g_cr
         localparam logic [4:0] NUM = 5'(gi);
         logic [31:0] nxt;
         always_comb
         begin
            nxt = cr_r[gi];
            if (acc_wr && access_in.num == NUM)
               nxt = access_in.wdata;
            if (NUM == ccr_pkg::CR_RECOVERY && rc_run)
               nxt = nxt - 32'h0000_0001; // RULE1
            if (NUM == ccr_pkg::CR_TIMER)
               nxt = nxt + 32'h0000_0001;
            if (NUM == ccr_pkg::CR_EXT_REQ)
               nxt = {20'h00000, nxt[11:0] | ext_sources}; // RULE11 RULE12 RULE13
            if (capture)
            begin
               if (NUM == ccr_pkg::CR_IAQ)
                  nxt = int_addr; // RULE2
               if (NUM == ccr_pkg::CR_IIR)
                  nxt = int_instr;
               if (NUM == ccr_pkg::CR_IOR)
                  nxt = int_offset;
               if (NUM == ccr_pkg::CR_IPSW)
                  nxt = int_status;
            end
         end
         always_ff @(posedge ref_clk or negedge rst_n)
         begin
            if (!rst_n)
               cr_r[gi] <= ccr_pkg::RESET_VALUE;
            else if (clk_en)
               cr_r[gi] <= nxt;
         end
      end
   endgenerate

   // Narrow shift and coprocessor fields.
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         shift_r <= 5'h00;
         coproc_r <= 8'h00;
      end
      else if (clk_en && acc_wr)
      begin
         if (access_in.num == ccr_pkg::CR_SHIFT)
            shift_r <= access_in.wdata[4:0]; // RULE6
         if (access_in.num == ccr_pkg::CR_COPROC)
            coproc_r <= access_in.wdata[7:0]; // RULE6
      end
   end

   // ====================================================================
   // Configuration registers.
   // ====================================================================
   // Config 0 and 3..6 by the core, 7 only by the emulation port.
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < 8; i++)
            cfg_r[i] <= ccr_pkg::RESET_VALUE;
      end
      else if (clk_en)
      begin
         if (cfg_valid && cfg_write &&
             (cfg_index == ccr_pkg::CFG_INTERNAL ||
              (cfg_index >= ccr_pkg::CFG_MEM_FIRST &&
               cfg_index <= ccr_pkg::CFG_MEM_LAST)))
            cfg_r[cfg_index] <= cfg_wdata; // RULE15
         if (emu_write)
            cfg_r[ccr_pkg::CFG_PC_DEBUG] <= emu_wdata; // RULE14
      end
   end

   // ====================================================================
   // Registered answers and event outputs.
   // ====================================================================
   // Answer and event pulses register one cycle after the request.
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         answer_r <= '0;
         cfg_rdata_r <= 32'h0000_0000;
         trap_r <= 1'b0;
         ext_int_r <= 1'b0;
         icache_inval_r <= 1'b0;
         dcache_inval_r <= 1'b0;
      end
      else if (clk_en)
      begin
         answer_r.valid <= access_in.valid;
         answer_r.trap <= acc_trap; // RULE23
         answer_r.rdata <= (access_in.valid && acc_ok) ? rd_mux : 32'h0;
         // Core reads of index 1, 2 and 7 return zero.
         cfg_rdata_r <= (cfg_index == ccr_pkg::CFG_INTERNAL ||
            (cfg_index >= ccr_pkg::CFG_MEM_FIRST &&
             cfg_index <= ccr_pkg::CFG_MEM_LAST)) ?
            cfg_r[cfg_index] : 32'h0; // RULE16
         trap_r <= rc_trap; // RULE1
         ext_int_r <= ext_raw; // RULE3
         icache_inval_r <= ic_toggle; // RULE17
         // Disabling the data cache raises no invalidate.
         dcache_inval_r <= dc_enable; // RULE18 RULE19
      end
   end

   assign answer_out = answer_r;
   assign cfg_rdata = cfg_rdata_r;
   assign emu_rdata = cfg_r[ccr_pkg::CFG_PC_DEBUG];
   assign recovery_trap = trap_r;
   assign ext_interrupt = ext_int_r;
   assign icache_inval = icache_inval_r;
   assign dcache_inval = dcache_inval_r;
   assign ext_requests = cr_r[ccr_pkg::CR_EXT_REQ][11:0];

   // ====================================================================
   // Assertions.
   // ====================================================================
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   sequence s_toggle;
      clk_en && ic_toggle;
   endsequence

   a_recovery_trap: assert property (clk_en && rc_trap |=> recovery_trap) // RULE1
      else $error("Recovery trap missing.");
   a_recovery_idle: assert property (clk_en && !status_in.recovery_en
      |=> !recovery_trap) // RULE1
      else $error("Recovery trap while disabled.");
   a_capture_off: assert property (clk_en && !status_in.collect_en
      |=> $stable(cr_r[ccr_pkg::CR_IIR]) || $past(acc_wr)) // RULE2
      else $error("State captured while disabled.");
   a_mask_off: assert property (clk_en && !status_in.unmask_en
      |=> !ext_interrupt) // RULE3
      else $error("Interrupt passed while masked.");
   a_hole_zero: assert property (clk_en && access_in.valid &&
      access_in.num == 5'h09 |=> answer_out.rdata == 32'h0) // RULE21
      else $error("Nonexistent register read not zero.");
   a_priv_trap: assert property (clk_en && access_in.valid &&
      !access_in.privileged && access_in.num == ccr_pkg::CR_IVB
      |=> answer_out.trap) // RULE10
      else $error("Unprivileged access did not trap.");
   a_shift_open: assert property (clk_en && access_in.valid &&
      access_in.num == ccr_pkg::CR_SHIFT |=> !answer_out.trap) // RULE7
      else $error("Shift register access trapped.");
   a_icache_flush: assert property (s_toggle |=> icache_inval) // RULE17
      else $error("Instruction cache not invalidated.");
   a_dcache_keep: assert property (clk_en && cfg0_wr && dc_old && !dc_new
      |=> !dcache_inval) // RULE19
      else $error("Data cache invalidated on disable.");

   // A user request: valid, enabled and below the privileged level.
   sequence s_user_req;
      clk_en && access_in.valid && !access_in.privileged;
   endsequence

   // An open interval timer answers user code without a trap.
   a_timer_open: assert property (s_user_req ##0 // RULE8
      (access_in.num == ccr_pkg::CR_TIMER && !status_in.secure_timer)
      |=> !answer_out.trap)
      else $error("Open timer access trapped.");

   // Request aims at temporary register 26 or 27.
   wire logic temp_num = (access_in.num == ccr_pkg::CR_TEMP_26) ||
      (access_in.num == ccr_pkg::CR_TEMP_27);

   // User writes to the shared temporaries are refused.
   a_temp_write: assert property (s_user_req ##0 // RULE9
      (temp_num && access_in.write) |=> answer_out.trap)
      else $error("User temporary write did not trap.");

   // A refused access returns zero and leaves the register alone.
   a_trap_zero: assert property (clk_en && acc_trap // RULE23
      |=> answer_out.rdata == 32'h0000_0000)
      else $error("Refused access returned data.");
   a_trap_keep: assert property (s_user_req ##0 // RULE23
      (access_in.write && access_in.num == ccr_pkg::CR_IVB)
      |=> $stable(cr_r[ccr_pkg::CR_IVB]))
      else $error("Refused write changed a register.");

   // Turning the data cache on raises an invalidate.
   a_dcache_flush: assert property (clk_en && dc_enable // RULE18
      |=> dcache_inval)
      else $error("Data cache not invalidated on enable.");

   // Every raised source shows in the request register next cycle.
   a_req_sticky: assert property (clk_en && // RULE11 RULE12 RULE13
      (|ext_sources) |=> &(ext_requests | ~$past(ext_sources)))
      else $error("Request source lost.");

   // With collection on, the queue takes the interrupted address.
   a_capture_on: assert property (clk_en && capture // RULE2
      |=> cr_r[ccr_pkg::CR_IAQ] == $past(int_addr))
      else $error("Interruption state not captured.");

   // The recovery counter holds while disabled and unwritten.
   a_recovery_hold: assert property (clk_en && !rc_run && // RULE1
      !(acc_wr && access_in.num == ccr_pkg::CR_RECOVERY)
      |=> $stable(cr_r[ccr_pkg::CR_RECOVERY]))
      else $error("Recovery counter moved while disabled.");

   // The program counter copy never reads back on the core side.
   a_debug_hidden: assert property (clk_en && // RULE14
      cfg_index == ccr_pkg::CFG_PC_DEBUG |=> cfg_rdata == 32'h0000_0000)
      else $error("Debug counter visible to the core.");

   // Clock enable low freezes answers and stored state.
   a_freeze_hold: assert property (!clk_en
      |=> $stable(answer_out) && $stable(emu_rdata))
      else $error("State moved while frozen.");

endmodule : ccr_bank

`default_nettype wire

// File: verif/ccr_bank_test.sv
// Self-checking testbench for the control register bank.
`timescale 1ns/1ps
`default_nettype none

module ccr_bank_test;
   // ==================================================================
   // Stimulus and observed signals.
   // ==================================================================
   logic ref_clk = 1'b0; // Core clock, 100 MHz.
   logic rst_n = 1'b0; // Asynchronous reset, active low.
   ccr_pkg::ccr_status_t st = '0; // Status word enables.
   ccr_pkg::ccr_access_t ac = '0; // Control register request.
   ccr_pkg::ccr_answer_t an; // Control register answer.
   logic cv = 1'b0, cw = 1'b0, ew = 1'b0, intr = 1'b0;
   logic pf = 1'b0, mcl = 1'b0, ce = 1'b1; // Sources; clock enable.
   logic [2:0] ci = 3'h0; // Configuration index.
   logic [31:0] cwd = 32'h0, ewd = 32'h0, crd, erd, iad = 32'h0;
   logic [11:0] src = 12'h0, ereq; // External request sources.
   logic rtrap, eint, iinv, dinv;
   int fail_count = 0; // Mismatches seen.
   int checks_done = 0; // Comparisons made.
   int cycles = 0; // Cycle counter for the hang guard.
   logic tr; // Trap flag of the last access.
   logic [31:0] rd; // Read data of the last access.

   always #5 ref_clk = ~ref_clk;

   ccr_bank uut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(ce),
      .status_in(st), .access_in(ac), .answer_out(an), .cfg_valid(cv),
      .cfg_write(cw), .cfg_index(ci), .cfg_wdata(cwd), .cfg_rdata(crd),
      .emu_write(ew), .emu_wdata(ewd), .emu_rdata(erd),
      .interruption(intr), .int_addr(iad), .int_instr(~iad),
      .int_offset(iad), .int_status(iad), .ext_sources(src),
      .power_fail(pf), .mc_low(mcl), .recovery_trap(rtrap),
      .ext_interrupt(eint), .icache_inval(iinv), .dcache_inval(dinv),
      .ext_requests(ereq));

   // ==================================================================
   // Shared tasks.
   // ==================================================================
   // Compares a value and reports a mismatch at once.
   task automatic chk(input logic [31:0] got, exp, input string m);
      checks_done++;
      if (got !== exp)
      begin
         fail_count++;
         $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk

   // One control access; the answer is read one cycle after the request.
   task automatic acc(input logic w, p, input logic [4:0] n,
                      input logic [31:0] d);
      @(posedge ref_clk);
      #1;
      ac = {1'b1, w, p, n, d};
      @(posedge ref_clk);
      #1;
      ac.valid = 1'b0;
      chk({31'h0, an.valid}, 32'h1, "answer valid");
      tr = an.trap;
      rd = an.rdata;
   endtask : acc

   // One configuration access; read data lands one cycle later.
   task automatic cfg(input logic w, input logic [2:0] i,
                      input logic [31:0] d);
      @(posedge ref_clk);
      #1;
      {cv, cw, ci, cwd} = {1'b1, w, i, d};
      @(posedge ref_clk);
      #1;
      cv = 1'b0;
      rd = crd;
   endtask : cfg

   // Closes the run with the verdict.
   task automatic give_verdict;
      if (fail_count == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : give_verdict

   // Hang guard: the scenarios need well under this many cycles.
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         fail_count++;
         $display("MISMATCH %0t timeout", $time);
         give_verdict();
      end
   end

   // ==================================================================
   // Scenarios.
   // ==================================================================
   // Shift field: any privilege, only five bits kept.
   task automatic t_shift;
      acc(1, 0, ccr_pkg::CR_SHIFT, 32'hffff_ffff);
      chk({31'h0, tr}, 32'h0, "shift write trap");
      acc(0, 0, ccr_pkg::CR_SHIFT, 32'h0);
      chk(rd, 32'h0000_001f, "shift width");
   endtask : t_shift

   // Reserved and missing numbers read zero and ignore writes.
   task automatic t_missing;
      logic [4:0] nums [7] = '{5'h01, 5'h07, 5'h08, 5'h09, 5'h0c,
                               5'h0d, 5'h11};
      foreach (nums[k])
      begin
         acc(1, 1, nums[k], 32'hdead_beef);
         acc(0, 1, nums[k], 32'h0);
         chk(rd, 32'h0, "missing reg read");
         chk({31'h0, tr}, 32'h0, "missing reg trap");
      end
      acc(0, 1, 5'h14, 32'h0);
      chk(rd, 32'h0, "reg 20 read");
   endtask : t_missing

   // Privileged-only register refuses user code and keeps its value.
   task automatic t_priv;
      acc(0, 1, ccr_pkg::CR_IVB, 32'h0);
      chk(rd, ccr_pkg::RESET_VALUE, "reset value");
      acc(1, 1, ccr_pkg::CR_IVB, 32'ha5a5_0000);
      acc(1, 0, ccr_pkg::CR_IVB, 32'h1234_5678);
      chk({31'h0, tr}, 32'h1, "user write trap");
      acc(0, 0, ccr_pkg::CR_IVB, 32'h0);
      chk({31'h0, tr}, 32'h1, "user read trap");
      chk(rd, 32'h0, "user read data");
      acc(0, 1, ccr_pkg::CR_IVB, 32'h0);
      chk(rd, 32'ha5a5_0000, "value kept");
   endtask : t_priv

   // Temporaries 26 and 27 read by all, written when privileged.
   task automatic t_temp;
      acc(1, 1, ccr_pkg::CR_TEMP_26, 32'h0bad_cafe);
      acc(0, 0, ccr_pkg::CR_TEMP_26, 32'h0);
      chk({31'h0, tr}, 32'h0, "user read 26 trap");
      chk(rd, 32'h0bad_cafe, "user read 26");
      acc(1, 0, ccr_pkg::CR_TEMP_27, 32'h1);
      chk({31'h0, tr}, 32'h1, "user write 27");
      acc(0, 0, ccr_pkg::CR_TEMP_27, 32'h0);
      chk({31'h0, tr}, 32'h0, "user read 27 trap");
      chk(rd, 32'h0, "27 unchanged");
   endtask : t_temp

   // Interval timer follows the secure bit.
   task automatic t_timer;
      acc(0, 0, ccr_pkg::CR_TIMER, 32'h0);
      chk({31'h0, tr}, 32'h0, "open timer");
      st.secure_timer = 1'b1;
      acc(0, 0, ccr_pkg::CR_TIMER, 32'h0);
      chk({31'h0, tr}, 32'h1, "secure timer user");
      acc(1, 1, ccr_pkg::CR_TIMER, 32'h0);
      chk({31'h0, tr}, 32'h0, "secure timer priv");
      st.secure_timer = 1'b0;
   endtask : t_timer

   // Recovery counter frozen when disabled, traps when enabled.
   task automatic t_recov;
      int n;
      acc(1, 1, ccr_pkg::CR_RECOVERY, 32'h4);
      repeat (4) @(posedge ref_clk);
      #1;
      chk({31'h0, rtrap}, 32'h0, "trap while off");
      acc(0, 1, ccr_pkg::CR_RECOVERY, 32'h0);
      chk(rd, 32'h4, "counter frozen");
      st.recovery_en = 1'b1;
      n = 0;
      while (rtrap !== 1'b1 && n < 6)
      begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      chk({31'h0, rtrap}, 32'h1, "recovery trap");
      st.recovery_en = 1'b0;
   endtask : t_recov

   // Request bits map one to one; the unmask bit gates the interrupt.
   task automatic t_ext;
      acc(1, 1, ccr_pkg::CR_EXT_MASK, 32'h0000_0fff);
      for (int i = 0; i < 12; i++)
      begin
         src = 12'h1 << i;
         acc(0, 1, ccr_pkg::CR_EXT_REQ, 32'h0);
         src = 12'h0;
         chk(rd, 32'h1 << i, "request bit");
         chk({20'h0, ereq}, 32'h1 << i, "request pins");
         repeat (2) @(posedge ref_clk);
         #1;
         chk({31'h0, eint}, 32'h0, "masked request");
         st.unmask_en = 1'b1;
         repeat (2) @(posedge ref_clk);
         #1;
         chk({31'h0, eint}, 32'h1, "unmasked request");
         st.unmask_en = 1'b0;
         acc(1, 1, ccr_pkg::CR_EXT_REQ, 32'hffff_f000);
      end
      {pf, st.unmask_en} = 2'b11;
      repeat (2) @(posedge ref_clk);
      #1;
      chk({31'h0, eint}, 32'h1, "power fail");
      {pf, mcl, st.unmask_en} = 3'b010;
      repeat (2) @(posedge ref_clk);
      #1;
      chk({31'h0, eint}, 32'h0, "machine check masked");
      st.unmask_en = 1'b1;
      repeat (2) @(posedge ref_clk);
      #1;
      chk({31'h0, eint}, 32'h1, "machine check");
      {mcl, st.unmask_en} = 2'b00;
   endtask : t_ext

   // Interruption state is captured only while collection is on.
   task automatic t_collect;
      iad = 32'h0000_1000;
      @(posedge ref_clk);
      #1;
      intr = 1'b1;
      @(posedge ref_clk);
      #1;
      intr = 1'b0;
      acc(0, 1, ccr_pkg::CR_IAQ, 32'h0);
      chk(rd, 32'h0, "no capture");
      st.collect_en = 1'b1;
      intr = 1'b1;
      @(posedge ref_clk);
      #1;
      intr = 1'b0;
      acc(0, 1, ccr_pkg::CR_IIR, 32'h0);
      chk(rd, 32'hffff_efff, "capture");
      st.collect_en = 1'b0;
   endtask : t_collect

   // Counts invalidate pulses over three cycles after a write.
   task automatic inval(input logic [31:0] d, input int ei, ed);
      int ni, nd;
      cfg(1, ccr_pkg::CFG_INTERNAL, d);
      ni = 0;
      nd = 0;
      repeat (3)
      begin
         ni += int'(iinv === 1'b1);
         nd += int'(dinv === 1'b1);
         @(posedge ref_clk);
         #1;
      end
      chk(ni, ei, "icache invalidate");
      chk(nd, ed, "dcache invalidate");
   endtask : inval

   // Cache toggles, memory settings and the debug copy of the counter.
   task automatic t_cfg;
      inval(32'h1, 1, 0);
      inval(32'h3, 0, 1);
      inval(32'h2, 1, 0);
      inval(32'h0, 0, 0);
      for (int i = 3; i < 7; i++)
      begin
         cfg(1, 3'(i), 32'h5a00_0000 + i);
         cfg(0, 3'(i), 32'h0);
         chk(rd, 32'h5a00_0000 + i, "memory config");
      end
      @(posedge ref_clk);
      #1;
      {ew, ewd} = {1'b1, 32'h0000_8000};
      @(posedge ref_clk);
      #1;
      ew = 1'b0;
      chk(erd, 32'h0000_8000, "debug counter");
      cfg(0, ccr_pkg::CFG_PC_DEBUG, 32'h0);
      chk(rd, 32'h0, "debug hidden");
   endtask : t_cfg

   // Clock enable low freezes state: an emulation write is lost.
   task automatic t_freeze;
      @(posedge ref_clk);
      #1;
      {ce, ew, ewd} = {1'b0, 1'b1, 32'h0000_4000};
      @(posedge ref_clk);
      #1;
      {ce, ew} = 2'b10;
      chk(erd, 32'h0000_8000, "frozen write");
   endtask : t_freeze

   // ==================================================================
   // Main sequence; configuration one and two stay untouched.
   // ==================================================================
   initial
   begin
      repeat (5) @(posedge ref_clk);
      #1;
      rst_n = 1'b1;
      t_shift();
      t_missing();
      t_priv();
      t_temp();
      t_timer();
      t_recov();
      t_ext();
      t_collect();
      t_cfg();
      t_freeze();
      give_verdict();
   end
endmodule : ccr_bank_test

`default_nettype wire
